//--- rtl/usft_pkg.sv
// package: register map, field layout and constants of the serial transmitter
package usft_pkg;
    // register offsets (byte addresses)
    localparam logic [3:0] USFT_ADDR_DATA = 4'h0;
    localparam logic [3:0] USFT_ADDR_STATUS = 4'h4;
    localparam logic [3:0] USFT_ADDR_CTRL_B = 4'h8;
    localparam logic [3:0] USFT_ADDR_CTRL_C = 4'hC;
    localparam logic [3:0] USFT_ADDR_BAUD_LO = 4'h1;
    localparam logic [3:0] USFT_ADDR_BAUD_HI = 4'h2;
    // status register fields
    localparam int USFT_ST_BUF_EMPTY = 5;
    localparam int USFT_ST_TX_DONE = 6;
    localparam int USFT_ST_DBL = 1;
    // control register b fields
    localparam int USFT_CB_NINTH = 0;
    localparam int USFT_CB_LEN2 = 2;
    localparam int USFT_CB_TXEN = 3;
    // control register c fields
    localparam int USFT_CC_POL = 0;
    localparam int USFT_CC_LEN_LO = 1;
    localparam int USFT_CC_STOP = 3;
    localparam int USFT_CC_PAR_LO = 4;
    localparam int USFT_CC_SYNC = 6;
    localparam int USFT_CC_MASTER = 7;
    // reset values
    localparam logic [7:0] USFT_CB_RESET = 8'h00;
    localparam logic [7:0] USFT_CC_RESET = 8'h06;
    localparam logic [11:0] USFT_BAUD_RESET = 12'h000;
    // data length code 7 selects nine data bits
    localparam logic [2:0] USFT_LEN_NINE = 3'h7;
    // baud tick divisors
    localparam logic [3:0] USFT_DIV_NORMAL = 4'hF;
    localparam logic [3:0] USFT_DIV_DOUBLE = 4'h7;
    localparam logic [3:0] USFT_DIV_SYNC = 4'h1;
    // shifter states, gray coded along start-data-parity-stop
    typedef enum logic [2:0] {
        USFT_IDLE = 3'b000,
        USFT_START = 3'b001,
        USFT_DATA = 3'b011,
        USFT_PARITY = 3'b010,
        USFT_STOP1 = 3'b110,
        USFT_STOP2 = 3'b111
    } usft_state_t;
endpackage

//--- rtl/usft_tx.sv
// serial frame transmitter with baud generator and register port
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Behaviour
// R1: length, parity and stop fields form one shared frame format.
// R2: receiver disregards second stop bit; framing error from first only.
// R3: software must not change frame format during a transfer.
// R4: parity is xor of data bits, inverted for odd parity.
// R5: parity bit sits after the msb and before the first stop.
// R6: stop bits are high; line idles high between frames.
// R7: software checks completion flags before reprogramming settings.
// R8: software clears the complete flag before writing the data register.
// R9: software masks interrupts while configuring the port.
// R10: transmit enable hands the data pin to the transmitter.
// R11: synchronous mode with transmitter enabled takes over the clock pin; here the pin is taken only when master is also set.
// R12: data register write loads the buffer and starts transmission.
// R13: buffer moves to shifter when idle or right after last stop.
// R14: a frame is sent at baud divider rate or external clock.
// R15: unused upper data bits are ignored for lengths below eight.
// R16: buffer empty flag shows the buffer accepts a character.
// R17: ninth bit is written to control before the data write.
// R18: length code 3 with stop select gives 8 data, 2 stops.
// R19: low start bit, data lsb first, 5 to 9 bits, 1 or 2 stops.
// R20: baud counter reloads at zero or low-byte write, one tick each; here a low-byte write reloads without a tick.
// R21: bit time is 16, 8 or 2 baud ticks by mode.
// R22: polarity bit picks the clock edge on which data changes.
// R23: empty flag sets on move to shifter, clears on data write.
// R24: complete flag sets after final stop with the buffer empty.
module usft_tx
    import usft_pkg::*;
#(
    parameter int BAUD_W = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // serial pins
    input wire logic xck_in,
    output logic tx_data_pin,
    output logic tx_data_oe_n,
    output logic xck_out,
    output logic xck_oe_n
);
    logic [7:0] ctrl_b_ff;
    logic [7:0] ctrl_c_ff;
    logic [BAUD_W-1:0] baud_ff;
    logic dbl_ff;
    logic [8:0] buf_ff;
    logic buf_full_ff;
    logic done_ff;
    logic [BAUD_W-1:0] bcnt_ff;
    logic [3:0] tick_cnt_ff;
    logic [8:0] shreg_ff;
    logic [3:0] bit_idx_ff;
    logic par_ff;
    usft_state_t state_ff;
    usft_state_t nxt_state;
    logic line_ff;
    logic xck_ff;
    logic xck_s1_ff;
    logic xck_s2_ff;
    logic xck_s3_ff;
    logic [7:0] rdata_ff;

    // decode
    wire wr_data = reg_wr && reg_addr == USFT_ADDR_DATA;
    wire wr_stat = reg_wr && reg_addr == USFT_ADDR_STATUS;
    wire wr_cb = reg_wr && reg_addr == USFT_ADDR_CTRL_B;
    wire wr_cc = reg_wr && reg_addr == USFT_ADDR_CTRL_C;
    wire wr_blo = reg_wr && reg_addr == USFT_ADDR_BAUD_LO;
    wire wr_bhi = reg_wr && reg_addr == USFT_ADDR_BAUD_HI;
    wire tx_en = ctrl_b_ff[USFT_CB_TXEN];
    // R1: control c plus the length msb in control b feed the whole frame
    wire [2:0] len_code = {ctrl_b_ff[USFT_CB_LEN2],
                           ctrl_c_ff[USFT_CC_LEN_LO+1 -: 2]};
    wire nine = len_code == USFT_LEN_NINE;
    // R19: codes 0..3 give 5..8 bits, code 7 gives 9
    wire [3:0] nbits = nine ? 4'h9 : {1'b0, len_code} + 4'h5;
    wire par_en = ctrl_c_ff[USFT_CC_PAR_LO+1];
    wire par_odd = ctrl_c_ff[USFT_CC_PAR_LO];
    wire two_stop = ctrl_c_ff[USFT_CC_STOP];
    wire sync = ctrl_c_ff[USFT_CC_SYNC];
    wire master = ctrl_c_ff[USFT_CC_MASTER];
    wire pol = ctrl_c_ff[USFT_CC_POL];

    // R20: reload at zero or on low-byte write, tick only when the count is zero
    wire baud_tick = bcnt_ff == '0;
    wire [BAUD_W-1:0] nxt_bcnt = (baud_tick || wr_blo) ? baud_ff
                                 : bcnt_ff - 1'b1;
    // R21: bit time in baud ticks
    wire [3:0] div_top = sync ? USFT_DIV_SYNC
                         : (dbl_ff ? USFT_DIV_DOUBLE : USFT_DIV_NORMAL);
    wire int_bit_tick = baud_tick && tick_cnt_ff == div_top;
    // master clock toggles once per half period, i.e. every baud tick
    wire int_half_tick = baud_tick;
    // R22: change edge on the synchronised external clock
    wire ext_rise = xck_s2_ff && !xck_s3_ff;
    wire ext_fall = !xck_s2_ff && xck_s3_ff;
    wire ext_change = pol ? ext_fall : ext_rise;
    // state moves on the sample edge; the registered line turns on the next
    wire mst_change = int_half_tick && (pol ? !xck_ff : xck_ff);
    // R14: shift timing from baud divider or external clock
    wire bit_tick = !sync ? int_bit_tick
                    : (master ? mst_change : ext_change);

    wire active = state_ff != USFT_IDLE;
    wire last_stop = bit_tick && (state_ff == USFT_STOP2 ||
                     (state_ff == USFT_STOP1 && !two_stop));
    // R13: load when idle or immediately after the last stop bit
    // pending data still drains after the enable is cleared mid-frame
    wire load = buf_full_ff && (active ? last_stop : tx_en);
    // R15: mask unused upper bits
    wire [8:0] len_mask = 9'h1FF >> (4'h9 - nbits);
    wire [8:0] masked = buf_ff & len_mask;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            USFT_IDLE: if (load) nxt_state = USFT_START;
            USFT_START: if (bit_tick) nxt_state = USFT_DATA;
            USFT_DATA: if (bit_tick && bit_idx_ff == nbits - 4'h1) begin
                // R5
                nxt_state = par_en ? USFT_PARITY : USFT_STOP1;
            end
            USFT_PARITY: if (bit_tick) nxt_state = USFT_STOP1;
            USFT_STOP1: if (bit_tick) begin
                nxt_state = two_stop ? USFT_STOP2 : USFT_IDLE; // R18
            end
            USFT_STOP2: if (bit_tick) nxt_state = USFT_IDLE; // R2
            default: nxt_state = USFT_IDLE;
        endcase
        if (load && active) nxt_state = USFT_START; // R13
    end

    wire nxt_line = (state_ff == USFT_START) ? 1'b0 // R19
                    : (state_ff == USFT_DATA) ? shreg_ff[0]
                    : (state_ff == USFT_PARITY) ? par_ff
                    : 1'b1; // R6
    // R4: parity over the masked character
    wire load_par = ^masked ^ par_odd;

    wire [7:0] status_val = {1'b0, done_ff, !buf_full_ff, 3'h0,
                             dbl_ff, 1'b0};
    wire [7:0] nxt_rdata =
        !reg_rd ? 8'h00
        : reg_addr == USFT_ADDR_STATUS ? status_val
        : reg_addr == USFT_ADDR_CTRL_B ? ctrl_b_ff
        : reg_addr == USFT_ADDR_CTRL_C ? ctrl_c_ff
        : reg_addr == USFT_ADDR_BAUD_LO ? baud_ff[7:0]
        : reg_addr == USFT_ADDR_BAUD_HI ? {4'h0, baud_ff[11:8]}
        : 8'h00;

    // configuration registers; format changes mid-frame are software's risk
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_b_ff <= USFT_CB_RESET;
            ctrl_c_ff <= USFT_CC_RESET;
            baud_ff <= USFT_BAUD_RESET;
            dbl_ff <= 1'b0;
        end else begin
            if (wr_cb) ctrl_b_ff <= reg_wdata;
            if (wr_cc) ctrl_c_ff <= reg_wdata;
            if (wr_blo) baud_ff[7:0] <= reg_wdata;
            if (wr_bhi) baud_ff[11:8] <= reg_wdata[3:0];
            if (wr_stat) dbl_ff <= reg_wdata[USFT_ST_DBL];
        end
    end

    // transmit buffer and flags
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            buf_ff <= '0;
            buf_full_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            if (wr_data) begin
                // R12 R17: ninth bit captured with the low byte
                buf_ff <= {ctrl_b_ff[USFT_CB_NINTH], reg_wdata};
                buf_full_ff <= 1'b1; // R23
            end else if (load) begin
                buf_full_ff <= 1'b0; // R16 R23
            end
            // R24: set wins over write-one clear
            if (last_stop && !load) done_ff <= 1'b1;
            else if (wr_stat && reg_wdata[USFT_ST_TX_DONE]) done_ff <= 1'b0;
        end
    end

    // baud counter and tick divider
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bcnt_ff <= '0;
            tick_cnt_ff <= '0;
        end else begin
            bcnt_ff <= nxt_bcnt;
            // every frame starts on a whole bit time
            if (load || !active) tick_cnt_ff <= '0;
            else if (baud_tick) begin
                tick_cnt_ff <= (tick_cnt_ff == div_top) ? 4'h0
                               : tick_cnt_ff + 4'h1;
            end
        end
    end

    // shifter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= USFT_IDLE;
            shreg_ff <= '0;
            bit_idx_ff <= '0;
            par_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (load) begin
                shreg_ff <= masked; // R15
                par_ff <= load_par; // R4
                bit_idx_ff <= '0;
            end else if (bit_tick && state_ff == USFT_DATA) begin
                shreg_ff <= {1'b0, shreg_ff[8:1]}; // R19
                bit_idx_ff <= bit_idx_ff + 4'h1;
            end
        end
    end

    // pins and synchroniser; first stage only feeds the second
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_ff <= 1'b1;
            xck_ff <= 1'b0;
            xck_s1_ff <= 1'b0;
            xck_s2_ff <= 1'b0;
            xck_s3_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            line_ff <= nxt_line; // R6
            xck_s1_ff <= xck_in;
            xck_s2_ff <= xck_s1_ff;
            xck_s3_ff <= xck_s2_ff;
            // idle clock level follows polarity
            if (!active) xck_ff <= pol;
            else if (int_half_tick) xck_ff <= !xck_ff;
            rdata_ff <= nxt_rdata;
        end
    end

    // R10: data pin driven while enabled or still draining
    // a character parked while disabled does not grab the pin
    wire drive_tx = tx_en || active;
    // R11: clock pin driven only as synchronous master
    wire drive_xck = drive_tx && sync && master;
    logic oe_tx_n_ff;
    logic oe_xck_n_ff;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oe_tx_n_ff <= 1'b1;
            oe_xck_n_ff <= 1'b1;
        end else begin
            oe_tx_n_ff <= !drive_tx; // R10
            oe_xck_n_ff <= !drive_xck; // R11
        end
    end

    assign reg_rdata = rdata_ff;
    assign tx_data_pin = line_ff;
    assign tx_data_oe_n = oe_tx_n_ff;
    assign xck_out = xck_ff;
    assign xck_oe_n = oe_xck_n_ff;
endmodule

//--- testbench/usft_tx_properties.sv
// checker: port properties of the serial frame transmitter
`timescale 1ns/1ps
module usft_tx_properties
    import usft_pkg::*;
(
    // clock, reset and register port
    input wire logic clk, sys_rst, reg_wr, reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    // serial pins
    input wire logic xck_in, tx_data_pin, tx_data_oe_n, xck_out, xck_oe_n
);
    logic [7:0] cb_ff, cc_ff, bl_ff;
    logic dbl_ff;
    logic [15:0] run_ff;
    // shadow settings so that bit times are known here
    wire logic sync = cc_ff[USFT_CC_SYNC];
    wire logic mst = sync && cc_ff[USFT_CC_MASTER];
    wire logic [15:0] per = (sync ? 16'h2 : dbl_ff ? 16'h8 : 16'h10)
        * ({8'h00, bl_ff} + 16'h1);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cb_ff <= USFT_CB_RESET;
            cc_ff <= USFT_CC_RESET;
            bl_ff <= 8'h00;
            dbl_ff <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == USFT_ADDR_CTRL_B) cb_ff <= reg_wdata;
            if (reg_addr == USFT_ADDR_CTRL_C) cc_ff <= reg_wdata;
            if (reg_addr == USFT_ADDR_BAUD_LO) bl_ff <= reg_wdata;
            if (reg_addr == USFT_ADDR_STATUS) dbl_ff <= reg_wdata[USFT_ST_DBL];
        end
    end
    // cycles since the line last changed; saturates on a long idle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) run_ff <= 16'h0;
        else if ($changed(tx_data_pin)) run_ff <= 16'h1;
        else if (run_ff != 16'hFFFF) run_ff <= run_ff + 16'h1;
    end
    chk_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_fmt_read: assert property (
        reg_rd && reg_addr == USFT_ADDR_CTRL_C |=> reg_rdata == cc_ff)
        else $error("frame format readback wrong");
    chk_ninth_read: assert property (
        reg_rd && reg_addr == USFT_ADDR_CTRL_B
        |=> (reg_rdata & 8'h0D) == (cb_ff & 8'h0D))
        else $error("control b readback wrong");
    chk_txen_grab: assert property (
        reg_wr && reg_addr == USFT_ADDR_CTRL_B && reg_wdata[USFT_CB_TXEN]
        |-> ##[1:2] !tx_data_oe_n)
        else $error("data pin not taken over");
    // judged only from a long idle line, where the shifter must be empty
    chk_start_edge: assert property (
        reg_wr && reg_addr == USFT_ADDR_DATA && cb_ff[USFT_CB_TXEN]
        && tx_data_pin && run_ff > 16'hC * per |-> ##3 !tx_data_pin)
        else $error("start bit late");
    chk_bit_grid: assert property (
        $rose(tx_data_pin) && !$past(tx_data_oe_n) && (mst || !sync)
        |-> run_ff % per == 16'h0)
        else $error("low run not whole bit times");
    chk_low_bound: assert property (
        $rose(tx_data_pin) && !$past(tx_data_oe_n) && (mst || !sync)
        |-> run_ff <= 16'hB * per)
        else $error("low run longer than a frame allows");
    chk_xck_owner: assert property (
        !xck_oe_n |-> $past(mst) || $past(mst, 2))
        else $error("clock pin driven outside sync master");
    cover property (reg_rd && reg_addr == USFT_ADDR_STATUS);
    cover property ($fell(tx_data_pin) && mst);
    cover property ($fell(tx_data_pin) && dbl_ff);
endmodule
bind usft_tx usft_tx_properties chk (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xck_in(xck_in),
    .tx_data_pin(tx_data_pin), .tx_data_oe_n(tx_data_oe_n),
    .xck_out(xck_out), .xck_oe_n(xck_oe_n));

//--- testbench/usft_far_rx.sv
// far-end model: a listening serial receiver on the data line
`timescale 1ns/1ps
module usft_far_rx (
    // clock and line
    input wire logic clk,
    input wire logic line,
    output logic xck_line,
    // frame setup and captured frames
    input wire logic [15:0] per,
    input wire logic [3:0] nbits,
    output logic [11:0] word,
    output logic ferr,
    output int cnt,
    output int gap
);
    int cyc = 0;
    int t0 = 0;
    // this end only listens, so its clock pin stands still
    assign xck_line = 1'b0;
    initial cnt = 0;
    always @(posedge clk) cyc <= cyc + 1;
    always begin
        @(negedge line);
        @(negedge clk);
        gap = cyc - t0;
        t0 = cyc;
        word = 12'h000;
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
            repeat (per) @(posedge clk);
            word[i] = line;
        end
        ferr = !line;
        cnt++;
    end
endmodule

//--- testbench/usft_tx_tb.sv
// testbench: register driven frames checked at the far end
`timescale 1ns/1ps
module usft_tx_tb;
    import usft_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0, nb_s = 4'hA;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, sd;
    logic tx_data_pin, tx_data_oe_n, xck_out, xck_oe_n, xck_in, fe;
    logic [15:0] per_s = 16'h10;
    logic [11:0] fw;
    logic [1:0] cur_pm = 2'h0;
    int num_errors = 0, num_checks = 0, nfr = 0, cur_n = 8, fc, fg;
    // pulled-up line: idle high whenever the pin is released
    wire logic line_w = tx_data_oe_n ? 1'b1 : tx_data_pin;
    always #50 clk = ~clk;
    usft_tx dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .xck_in(xck_in), .tx_data_pin(tx_data_pin),
        .tx_data_oe_n(tx_data_oe_n), .xck_out(xck_out), .xck_oe_n(xck_oe_n));
    usft_far_rx far (.clk(clk), .line(line_w), .xck_line(xck_in),
        .per(per_s), .nbits(nb_s), .word(fw), .ferr(fe), .cnt(fc), .gap(fg));
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(logic [11:0] got, logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(logic [3:0] a, logic [7:0] m, logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        sd = reg_rdata;
        if (m != 8'h00) check({4'h0, sd & m}, {4'h0, e});
    endtask
    function automatic logic [11:0] frame_of(logic [8:0] d);
        logic [11:0] w;
        logic p;
        int n;
        w = 12'h000;
        p = cur_pm[0];
        n = cur_n;
        for (int i = 0; i < n; i++) begin
            w[i] = d[i];
            p ^= d[i];
        end
        if (cur_pm[1]) begin
            w[n] = p;
            n++;
        end
        w[n] = 1'b1;
        return w;
    endfunction
    task automatic send(logic [2:0] lc, logic [1:0] pm, logic st, logic dbl,
            logic [1:0] md, logic [8:0] d);
        repeat (250) @(posedge clk);
        cur_n = (lc == USFT_LEN_NINE) ? 9 : lc + 5;
        cur_pm = pm;
        per_s <= md[1] ? 16'h2 : (dbl ? 16'h8 : 16'h10);
        nb_s <= 4'(cur_n + pm[1] + 1);
        wr(USFT_ADDR_CTRL_C, {md, pm, st, lc[1:0], 1'b0});
        // no interrupt enables in this port, so nothing to mask here
        wr(USFT_ADDR_CTRL_B, {4'h0, 1'b1, lc[2], 1'b0, d[8]});
        wr(USFT_ADDR_STATUS, {1'b0, 1'b1, 4'h0, dbl, 1'b0});
        wr(USFT_ADDR_DATA, d[7:0]);
    endtask
    task automatic take(logic [8:0] d);
        nfr++;
        for (int i = 0; i < 5000 && fc < nfr; i++) @(posedge clk);
        if (fc < nfr) begin
            check(12'h001, 12'h000);
            print_verdict();
        end
        check(fw, frame_of(d));
        check({11'h0, fe}, 12'h000);
    endtask
    task automatic done_chk();
        sd = 8'h00;
        for (int i = 0; i < 60 && sd[6] !== 1'b1; i++)
            rdc(USFT_ADDR_STATUS, 8'h00, 8'h00);
        check({4'h0, sd & 8'h60}, 12'h060);
        if (sd[6] !== 1'b1) print_verdict();
    endtask
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rdc(USFT_ADDR_CTRL_B, 8'hFF, 8'h00);
        rdc(USFT_ADDR_CTRL_C, 8'hFF, 8'h06);
        rdc(USFT_ADDR_STATUS, 8'h62, 8'h20);
        rdc(4'h3, 8'hFF, 8'h00);
        send(3'h0, 2'h2, 1'b0, 1'b0, 2'h0, 9'h0FF);
        take(9'h0FF);
        done_chk();
        send(3'h1, 2'h3, 1'b1, 1'b1, 2'h0, 9'h0E5);
        take(9'h0E5);
        send(3'h2, 2'h0, 1'b0, 1'b0, 2'h0, 9'h0AA);
        take(9'h0AA);
        send(3'h3, 2'h2, 1'b1, 1'b0, 2'h0, 9'h081);
        take(9'h081);
        send(3'h7, 2'h3, 1'b0, 1'b0, 2'h0, 9'h1A5);
        take(9'h1A5);
        done_chk();
        // second character queued while the first is on the line
        send(3'h3, 2'h0, 1'b0, 1'b0, 2'h0, 9'h055);
        wr(USFT_ADDR_DATA, 8'h3C);
        rdc(USFT_ADDR_STATUS, 8'h20, 8'h00);
        take(9'h055);
        take(9'h03C);
        check(fg[11:0], 12'h0A0);
        done_chk();
        send(3'h3, 2'h0, 1'b0, 1'b0, 2'h3, 9'h0C3);
        check({11'h0, xck_oe_n}, 12'h000);
        repeat (3) @(negedge clk);
        sd[0] = xck_out;
        @(negedge clk);
        check({11'h0, sd[0] ^ xck_out}, 12'h001);
        take(9'h0C3);
        // with the transmitter off a written character must stay put
        wr(USFT_ADDR_CTRL_B, 8'h00);
        repeat (40) @(posedge clk);
        wr(USFT_ADDR_DATA, 8'h99);
        repeat (100) @(posedge clk);
        check({11'h0, tx_data_oe_n}, 12'h001);
        check(fc[11:0], 12'(nfr));
        print_verdict();
    end
endmodule
